/* File: inc/guard_defs.svh */
// Offsets, field positions, reset values and sizes for the code segment write guard
`ifndef GUARD_DEFS_SVH
`define GUARD_DEFS_SVH

// Program memory word address and 512-word page geometry
`define ADDR_W 15
`define PAGE_WORDS 512
`define PAGE_LSB 9
`define PAGE_MSB 14
`define PAGE_W 6
// Index of the last implemented page; plain default, set per memory size
`define LAST_PAGE 6'h3F

// Configuration word layout
`define CFG_W 11
`define CFG_PAGE_MSB 5
`define CFG_DIR_BIT 6
`define CFG_LASTN_BIT 7
`define CFG_DIS_BIT 8
`define CFG_GWP_BIT 9
`define CFG_CODE_PROT_BIT 10
// Erased flash reads all ones: global write protect set, every page protected
`define CFG_RST 11'h7FF

// AXI4-Lite register map, byte addresses
`define AXI_AW 5
`define OFS_CONFIG 5'h00
`define OFS_STATUS 5'h04
`define OFS_MASK 5'h08
`define OFS_BLOCK_ADDR 5'h0C
`define OFS_CTRL 5'h10

// Status, mask and control bit positions
`define EVT_W 2
`define EVT_BLOCKED 0
`define EVT_PARITY 1
`define CTRL_RELOAD 0

// AXI response codes
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

/* File: inc/guard_pkg.sv */
// Types shared by the code segment write guard and its configuration store
`include "guard_defs.svh"

package guard_pkg;

  typedef enum logic [0:0] {
    WR_COLLECT = 1'b0,
    WR_RESP = 1'b1
  } wr_state_t;

  typedef enum logic [0:0] {
    RD_IDLE = 1'b0,
    RD_DATA = 1'b1
  } rd_state_t;

  // Same bit order as the configuration word
  typedef struct packed {
    logic global_code_protect;
    logic gwp;
    logic dis;
    logic last_n;
    logic dir;
    logic [`PAGE_W-1:0] page;
  } cfg_t;

  typedef struct packed {
    logic [`CFG_W-1:0] live;
    logic [`CFG_W-1:0] shadow;
    logic mismatch;
  } shadow_state_t;

  typedef struct packed {
    wr_state_t wr;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic aw_held;
    logic w_held;
    logic [`AXI_AW-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    rd_state_t rd;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [`EVT_W-1:0] status;
    logic [`EVT_W-1:0] mask;
    logic irq;
    logic [`ADDR_W-1:0] block_addr;
    logic loaded;
    logic load_pulse;
    logic reload_req;
    logic resp_valid;
    logic resp_blocked;
    logic interlock;
    logic reset_req;
  } guard_state_t;

endpackage : guard_pkg

/* File: rtl/code_segment_write_guard.sv */
// Write and erase guard for program flash with configuration integrity check
`timescale 1ns/1ps
`include "guard_defs.svh"

module code_segment_write_guard (
  input wire logic clk, // System clock, 200 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [`AXI_AW-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [`AXI_AW-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic req_valid, // Write or erase request, one cycle
  input wire logic [`ADDR_W-1:0] req_addr, // Target word address
  input wire logic req_erase, // Request is an erase
  input wire logic [`CFG_W-1:0] cfg_word, // Configuration word from flash
  input wire logic cfg_load, // Reload configuration from flash
  input wire logic [`CFG_W-1:0] cell_upset, // Disturbance on config cells
  output logic resp_valid, // Check result valid, one cycle
  output logic resp_blocked, // Request refused
  output logic interlock_enable, // Safety interlock released, one cycle
  output logic irq, // Level interrupt
  output logic device_reset_req // Device reset after parity error
);

  guard_pkg::guard_state_t st;
  guard_pkg::guard_state_t next_st;
  guard_pkg::cfg_t cfg;
  logic [`CFG_W-1:0] cfg_bits;
  logic mismatch;

  // Page index of a word address
  function automatic logic [`PAGE_W-1:0] page_of(input logic [`ADDR_W-1:0] a);
    page_of = a[`PAGE_MSB:`PAGE_LSB];
  endfunction : page_of

  // Whether any protection covers a page
  function automatic logic guarded(input logic [`PAGE_W-1:0] pg, input guard_pkg::cfg_t c);
    logic seg;
    logic last;
    logic glob;
    seg = 1'b0;
    if (!c.dis) begin
      if (c.dir) begin
        seg = (pg >= c.page);
      end else begin
        seg = (pg <= c.page);
      end
    end
    last = !c.last_n && (pg == `LAST_PAGE);
    // Config source words sit in the last page
    glob = c.gwp || (c.global_code_protect && (pg == `LAST_PAGE));
    guarded = seg || last || glob;
  endfunction : guarded

  // Live configuration and its complemented shadow
  config_shadow_store u_store (
    .clk(clk),
    .rst(rst),
    .load(st.load_pulse),
    .load_value(cfg_word),
    .cell_upset(cell_upset),
    .live(cfg_bits),
    .mismatch(mismatch)
  );

  assign cfg = guard_pkg::cfg_t'(cfg_bits);

  // Next state of the whole block
  always_comb begin
    logic [`EVT_W-1:0] evt;
    logic [`EVT_W-1:0] clr;
    logic hit;
    evt = '0;
    clr = '0;
    hit = 1'b0;
    next_st = st;
    next_st.load_pulse = 1'b0;
    next_st.resp_valid = 1'b0;
    next_st.interlock = 1'b0;

    // First load right after reset, later on request
    if (!st.loaded || cfg_load || st.reload_req) begin
      next_st.load_pulse = 1'b1;
      next_st.loaded = 1'b1;
      next_st.reload_req = 1'b0;
    end

    // Check decided before the operation may start
    if (req_valid) begin
      hit = guarded(page_of(req_addr), cfg);
      next_st.resp_valid = 1'b1;
      next_st.resp_blocked = hit;
      next_st.interlock = !hit;
      if (hit) begin
        next_st.block_addr = req_addr;
        evt[`EVT_BLOCKED] = 1'b1;
      end
    end

    // Parity error holds the reset request until the device resets
    if (mismatch) begin
      evt[`EVT_PARITY] = 1'b1;
      next_st.reset_req = 1'b1;
    end

    // Write address and data taken in either order
    if (st.awready && s_axi_awvalid) begin
      next_st.aw_held = 1'b1;
      next_st.waddr = s_axi_awaddr;
    end
    if (st.wready && s_axi_wvalid) begin
      next_st.w_held = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end

    // Write side
    unique case (st.wr)
      guard_pkg::WR_COLLECT: begin
        if (st.aw_held && st.w_held) begin
          next_st.aw_held = 1'b0;
          next_st.w_held = 1'b0;
          next_st.bvalid = 1'b1;
          next_st.bresp = `RESP_OKAY;
          next_st.wr = guard_pkg::WR_RESP;
          unique case ({st.waddr[`AXI_AW-1:2], 2'b00})
            `OFS_CONFIG, `OFS_BLOCK_ADDR: begin
              next_st.bresp = `RESP_OKAY;
            end
            `OFS_STATUS: begin
              if (st.wstrb[0]) begin
                clr = st.wdata[`EVT_W-1:0];
              end
            end
            `OFS_MASK: begin
              if (st.wstrb[0]) begin
                next_st.mask = st.wdata[`EVT_W-1:0];
              end
            end
            `OFS_CTRL: begin
              if (st.wstrb[0] && st.wdata[`CTRL_RELOAD]) begin
                next_st.reload_req = 1'b1;
              end
            end
            default: begin
              next_st.bresp = `RESP_DECERR;
            end
          endcase
        end
      end
      guard_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          next_st.bvalid = 1'b0;
          next_st.wr = guard_pkg::WR_COLLECT;
        end
      end
    endcase
    // No new address or data until the response is taken
    next_st.awready = !next_st.aw_held && (next_st.wr == guard_pkg::WR_COLLECT);
    next_st.wready = !next_st.w_held && (next_st.wr == guard_pkg::WR_COLLECT);

    // Read side
    unique case (st.rd)
      guard_pkg::RD_IDLE: begin
        if (st.arready && s_axi_arvalid) begin
          next_st.arready = 1'b0;
          next_st.rvalid = 1'b1;
          next_st.rdata = '0;
          next_st.rresp = `RESP_OKAY;
          next_st.rd = guard_pkg::RD_DATA;
          unique case ({s_axi_araddr[`AXI_AW-1:2], 2'b00})
            `OFS_CONFIG: next_st.rdata[`CFG_W-1:0] = cfg_bits;
            `OFS_STATUS: next_st.rdata[`EVT_W-1:0] = st.status;
            `OFS_MASK: next_st.rdata[`EVT_W-1:0] = st.mask;
            `OFS_BLOCK_ADDR: next_st.rdata[`ADDR_W-1:0] = st.block_addr;
            `OFS_CTRL: next_st.rdata = '0;
            default: next_st.rresp = `RESP_DECERR;
          endcase
        end
      end
      guard_pkg::RD_DATA: begin
        if (s_axi_rready) begin
          next_st.rvalid = 1'b0;
          next_st.arready = 1'b1;
          next_st.rd = guard_pkg::RD_IDLE;
        end
      end
    endcase

    // An event in the clearing cycle stays set
    next_st.status = (st.status & ~clr) | evt;
    next_st.irq = |(next_st.status & next_st.mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign resp_valid = st.resp_valid;
  assign resp_blocked = st.resp_blocked;
  assign interlock_enable = st.interlock;
  assign irq = st.irq;
  assign device_reset_req = st.reset_req;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Request and its two possible replies
  sequence s_req;
    req_valid;
  endsequence
  sequence s_refused;
    resp_valid && resp_blocked && !interlock_enable;
  endsequence
  sequence s_granted;
    resp_valid && !resp_blocked && interlock_enable;
  endsequence

  property p_block;
    s_req ##0 guarded(page_of(req_addr), cfg) |=> s_refused;
  endproperty
  a_block: assert property (p_block) else $error("protected request not refused");

  property p_grant;
    s_req ##0 !guarded(page_of(req_addr), cfg) |=> s_granted;
  endproperty
  a_grant: assert property (p_grant) else $error("free request not granted");

  property p_no_stray_interlock;
    !req_valid |=> !interlock_enable && !resp_valid;
  endproperty
  a_no_stray_interlock: assert property (p_no_stray_interlock)
    else $error("interlock without request");

  property p_none_enabled;
    s_req ##0 (cfg.dis && cfg.last_n && !cfg.gwp && !cfg.global_code_protect) |=> s_granted;
  endproperty
  a_none_enabled: assert property (p_none_enabled)
    else $error("blocked with no protection");

  property p_low_range;
    s_req ##0 (!cfg.dis && !cfg.dir && page_of(req_addr) <= cfg.page) |=> s_refused;
  endproperty
  a_low_range: assert property (p_low_range)
    else $error("bottom segment write allowed");

  property p_low_above;
    s_req ##0 (!cfg.dis && !cfg.dir && cfg.last_n && !cfg.gwp && !cfg.global_code_protect
      && page_of(req_addr) > cfg.page) |=> s_granted;
  endproperty
  a_low_above: assert property (p_low_above)
    else $error("write above bottom segment refused");

  property p_high_range;
    s_req ##0 (!cfg.dis && cfg.dir && page_of(req_addr) >= cfg.page) |=> s_refused;
  endproperty
  a_high_range: assert property (p_high_range) else $error("top segment write allowed");

  property p_boundary;
    s_req ##0 (!cfg.dis && page_of(req_addr) == cfg.page) |=> resp_blocked;
  endproperty
  a_boundary: assert property (p_boundary) else $error("boundary page not protected");

  property p_last_page;
    s_req ##0 (!cfg.last_n && page_of(req_addr) == `LAST_PAGE) |=> s_refused;
  endproperty
  a_last_page: assert property (p_last_page) else $error("last page write allowed");

  property p_global;
    s_req ##0 cfg.gwp |=> s_refused;
  endproperty
  a_global: assert property (p_global) else $error("global protection lifted");

  property p_cfg_source;
    s_req ##0 (cfg.global_code_protect && page_of(req_addr) == `LAST_PAGE) |=> s_refused;
  endproperty
  a_cfg_source: assert property (p_cfg_source)
    else $error("config words writable under code protect");

  property p_parity;
    mismatch |=> device_reset_req ##0 st.status[`EVT_PARITY];
  endproperty
  a_parity: assert property (p_parity) else $error("parity error not acted on");

  property p_shadow_load;
    st.load_pulse && cell_upset == '0 ##1 cell_upset == '0 |=> !mismatch;
  endproperty
  a_shadow_load: assert property (p_shadow_load)
    else $error("clean load reports mismatch");

  // Erases go through the same check as writes
  property p_erase_checked;
    s_req ##0 req_erase ##0 guarded(page_of(req_addr), cfg) |=> s_refused;
  endproperty
  a_erase_checked: assert property (p_erase_checked)
    else $error("protected erase not refused");

  property p_block_addr;
    s_req ##0 guarded(page_of(req_addr), cfg) |=> st.block_addr == $past(req_addr);
  endproperty
  a_block_addr: assert property (p_block_addr)
    else $error("refused address not recorded");

  // A live bit flipped outside a load shows up two edges later
  property p_upset_seen;
    cell_upset != '0 && !st.load_pulse |=> ##1 mismatch;
  endproperty
  a_upset_seen: assert property (p_upset_seen)
    else $error("cell upset not detected");

  // Reset request stays up until the device reset comes
  property p_reset_held;
    device_reset_req |=> device_reset_req;
  endproperty
  a_reset_held: assert property (p_reset_held)
    else $error("device reset request dropped");

endmodule : code_segment_write_guard

/* File: rtl/config_shadow_store.sv */
// Live configuration bits with a complemented shadow copy and mismatch flag
`timescale 1ns/1ps
`include "guard_defs.svh"

module config_shadow_store (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic load, // Load pulse from the flash word
  input wire logic [`CFG_W-1:0] load_value, // Configuration word from flash
  input wire logic [`CFG_W-1:0] cell_upset, // Bit flips on live cells
  output logic [`CFG_W-1:0] live, // Live configuration bits
  output logic mismatch // Live and shadow disagree
);

  guard_pkg::shadow_state_t st;
  guard_pkg::shadow_state_t next_st;

  // Load both copies together; upsets only touch the live cells
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.live = load_value;
      next_st.shadow = ~load_value;
    end else begin
      next_st.live = st.live ^ cell_upset;
    end
    // Compared every cycle, not only at load
    next_st.mismatch = (st.live != ~st.shadow);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st.live <= `CFG_RST;
      st.shadow <= ~`CFG_RST;
      st.mismatch <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign live = st.live;
  assign mismatch = st.mismatch;

endmodule : config_shadow_store

/* File: test/flash_ctrl_model.sv */
// Flash programming controller model issuing write and erase requests
`timescale 1ns/1ps
`include "guard_defs.svh"

module flash_ctrl_model (
  input wire logic clk, // System clock
  input wire logic rst, // Synchronous reset
  input wire logic go, // Issue one request
  input wire logic [`ADDR_W-1:0] go_addr, // Target word address
  input wire logic go_erase, // Request is an erase
  output logic req_valid, // Request strobe
  output logic [`ADDR_W-1:0] req_addr, // Request address
  output logic req_erase, // Request erase flag
  input wire logic resp_valid, // Check result valid
  input wire logic resp_blocked, // Request refused
  input wire logic interlock_enable, // Interlock released
  output logic done, // Answer seen, one cycle
  output logic blocked, // Latched refusal
  output logic allowed, // Latched interlock release
  output logic stray // Interlock seen without an answer
);
  // One request per go; idle address toggles so stale values never pass
  always_ff @(posedge clk) begin
    req_valid <= 1'b0;
    done <= 1'b0;
    req_addr <= ~req_addr;
    if (rst) begin
      req_addr <= 15'h0000;
      req_erase <= 1'b0;
      stray <= 1'b0;
    end else if (go) begin
      req_valid <= 1'b1;
      req_addr <= go_addr;
      req_erase <= go_erase;
    end
    if (!rst && resp_valid) begin
      done <= 1'b1;
      blocked <= resp_blocked;
      allowed <= interlock_enable;
    end
    if (!rst && interlock_enable && !resp_valid) begin
      stray <= 1'b1;
    end
  end
endmodule : flash_ctrl_model

/* File: test/tb.sv */
// Self-checking testbench for the code segment write guard
`timescale 1ns/1ps
`include "guard_defs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end

module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [`AXI_AW-1:0] s_axi_awaddr = 5'h00;
  logic [`AXI_AW-1:0] s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic req_valid, req_erase, resp_valid, resp_blocked, interlock_enable, irq;
  logic device_reset_req, done, blocked, allowed, stray;
  logic [`ADDR_W-1:0] req_addr;
  logic [`ADDR_W-1:0] go_addr = 15'h0000;
  logic go = 1'b0;
  logic go_erase = 1'b0;
  logic cfg_load = 1'b0;
  logic [`CFG_W-1:0] cfg_word = 11'h1C5;
  logic [`CFG_W-1:0] cell_upset = 11'h000;
  logic [31:0] rd;
  logic [1:0] rs;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  // Config cases: none, last page, up from 5, down to 5, both, global write,
  // code protect, up from last page, down to page 0
  logic [10:0] cfgs [9] = '{11'h1C5, 11'h145, 11'h0C5, 11'h085, 11'h005, 11'h3C5,
    11'h5C5, 11'h0FF, 11'h080};
  logic [14:0] addrs [10] = '{15'h0000, 15'h01FF, 15'h0200, 15'h09FF, 15'h0A00,
    15'h0BFF, 15'h0C00, 15'h7DFF, 15'h7E00, 15'h7FFF};

  code_segment_write_guard DUT (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .req_valid, .req_addr, .req_erase,
    .cfg_word, .cfg_load, .cell_upset, .resp_valid, .resp_blocked, .interlock_enable,
    .irq, .device_reset_req);

  flash_ctrl_model partner (.clk, .rst, .go, .go_addr, .go_erase, .req_valid, .req_addr,
    .req_erase, .resp_valid, .resp_blocked, .interlock_enable, .done, .blocked, .allowed,
    .stray);

  // Clock and hang guard; ceiling well above the several hundred cycles needed
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task print_verdict;
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // Address and data offered together, each released once taken
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw = 1'b1;
    w = 1'b1;
    while (aw || w) begin
      @(posedge clk);
      if (aw && s_axi_awready === 1'b1) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready === 1'b1) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [4:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    @(posedge clk);
    while (s_axi_arready !== 1'b1) @(posedge clk);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge clk);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    axi_rd(a);
    `CHK(rd, e)
    `CHK(rs, `RESP_OKAY)
  endtask : rchk

  task automatic load(input logic [10:0] c);
    @(posedge clk);
    cfg_word <= c;
    cfg_load <= 1'b1;
    @(posedge clk);
    cfg_load <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : load

  task automatic req(input logic [14:0] a, input logic e, input logic x);
    @(posedge clk);
    go <= 1'b1;
    go_addr <= a;
    go_erase <= e;
    @(posedge clk);
    go <= 1'b0;
    while (done !== 1'b1) @(posedge clk);
    `CHK(blocked, x)
    `CHK(allowed, ~x)
  endtask : req

  // Reference decision built from the segment, last page and global settings
  function automatic logic exp_blk(input logic [10:0] c, input logic [14:0] a);
    logic [5:0] p;
    p = a[14:9];
    return (!c[8] && (c[6] ? p >= c[5:0] : p <= c[5:0])) || (!c[7] && p == `LAST_PAGE)
      || c[9] || (c[10] && p == `LAST_PAGE);
  endfunction : exp_blk

  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rchk(`OFS_CONFIG, 32'h000001C5);
    axi_wr(`OFS_CONFIG, 32'h00000000, rs);
    `CHK(rs, `RESP_OKAY)
    rchk(`OFS_CONFIG, 32'h000001C5);
    axi_rd(5'h14);
    `CHK(rs, `RESP_DECERR)
    `CHK(rd, 32'h00000000)
    axi_wr(5'h14, 32'h00000001, rs);
    `CHK(rs, `RESP_DECERR)
    rchk(`OFS_CTRL, 32'h00000000);
    $display("test registers done");
    foreach (cfgs[i]) begin
      load(cfgs[i]);
      rchk(`OFS_CONFIG, {21'h0, cfgs[i]});
      foreach (addrs[j]) begin
        req(addrs[j], j[0], exp_blk(cfgs[i], addrs[j]));
      end
    end
    `CHK(stray, 1'b0)
    $display("test protection table done");
    axi_wr(`OFS_STATUS, 32'h00000003, rs);
    rchk(`OFS_STATUS, 32'h00000000);
    axi_wr(`OFS_MASK, 32'h00000001, rs);
    rchk(`OFS_MASK, 32'h00000001);
    // Reload through the control register instead of the load pin
    cfg_word <= 11'h3C5;
    axi_wr(`OFS_CTRL, 32'h00000001, rs);
    repeat (3) @(posedge clk);
    rchk(`OFS_CONFIG, 32'h000003C5);
    req(15'h1234, 1'b1, 1'b1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    rchk(`OFS_BLOCK_ADDR, 32'h00001234);
    rchk(`OFS_STATUS, 32'h00000001);
    axi_wr(`OFS_STATUS, 32'h00000001, rs);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    axi_wr(`OFS_MASK, 32'h00000000, rs);
    req(15'h0400, 1'b0, 1'b1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    $display("test interrupt done");
    axi_wr(`OFS_MASK, 32'h00000002, rs);
    @(posedge clk);
    cell_upset <= 11'h001;
    @(posedge clk);
    cell_upset <= 11'h000;
    repeat (4) @(posedge clk);
    `CHK(device_reset_req, 1'b1)
    `CHK(irq, 1'b1)
    axi_rd(`OFS_STATUS);
    `CHK(rd[1], 1'b1)
    $display("test parity done");
    // Reset in mid-run: reset request dropped, config reloaded clean
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(device_reset_req, 1'b0)
    `CHK(irq, 1'b0)
    rchk(`OFS_STATUS, 32'h00000000);
    rchk(`OFS_CONFIG, 32'h000003C5);
    req(15'h0000, 1'b0, 1'b1);
    $display("test reset done");
    print_verdict();
  end
endmodule : tb
